// >>> rtl/rtc_regs.sv
// RTC time, calendar, alarm and status registers behind an APB slave
// Function
// - Mode bit 0 clear selects 24-hour counting, set selects 12-hour counting.
// - Mode and alarm register writes are ignored while write protection is enabled.
// - Second and minute fields are BCD, accepted range 0 to 59.
// - Low nibble holds units digit, upper bits hold tens digit.
// - Hour accepts 1-12 in 12-hour format, 0-23 in 24-hour format.
// - Time bit 22 means AM at 0, PM at 1, used in 12-hour format.
// - Century field accepts only BCD 20.
// - Year field is BCD, accepted range 00 to 99.
// - Month field is BCD, accepted range 01 to 12.
// - Day of week accepts 1 to 7 and does not affect date counting.
// - Day of month is BCD, accepted range 01 to 31.
// - Time alarm compares second, minute, hour with meridiem, each when enabled.
// - Date alarm compares day of month and month, each when enabled.
// - Acknowledge status bit 0 reads 1 when updates allowed, else 0.
// - Alarm status bit 1 becomes 1 on an alarm match.
// - Second event status bit 2 sets on a second event and stays set.
// - Time event bit 3 latches on selected minute, hour, noon or midnight.
// - Calendar event bit latches on selected week, month or year change.
// - Writing 1 to a clear command bit clears that flag; 0 does nothing.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "rtc_regs_consts.svh"

module rtc_regs
  import rtc_regs_pkg::*;
#(
  parameter int unsigned TICKS_PER_SECOND = `TICKS_PER_SECOND
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic bcd_in(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v[3:0] <= 4'h9) && (v >= lo) && (v <= hi);
  endfunction

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  // Year is 2000-2099, so divisibility by four is the whole leap test
  function automatic logic [7:0] last_date(input logic [4:0] month, input logic [7:0] year);
    logic [1:0] mod4;
    mod4 = {year[4], 1'b0} + year[1:0];
    unique case (month)
      5'h02: last_date = (mod4 == 2'd0) ? 8'h29 : 8'h28;
      5'h04, 5'h06, 5'h09, 5'h11: last_date = 8'h30;
      default: last_date = 8'h31;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tod_t tm;
  cal_t cal;
  tod_t next_tm;
  cal_t next_cal;
  logic hour_format_select;
  logic write_protect_enable;
  logic [31:0] time_alarm;
  logic [31:0] date_alarm;
  logic [31:0] control;
  logic [4:0] status;
  run_state_t state;
  logic [31:0] tick_count;
  logic tick;
  logic advance;
  logic advance_d;
  logic ev_min, ev_hour, ev_noon, ev_mid, ev_week, ev_month, ev_year;
  logic time_ev_hit, cal_ev_hit, alarm_hit, any_en;
  localparam logic [31:0] RST_TOD = `RESET_TIME_OF_DAY;
  localparam logic [31:0] RST_CAL = `RESET_CALENDAR_DATE;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic access, wr;
  logic sel_ctl, sel_mode, sel_time, sel_cal, sel_talm, sel_dalm, sel_stat, sel_clr, sel_wp;
  logic time_ok, cal_ok;
  logic [7:0] w_hour;

  assign access = psel & penable & pready;
  assign wr = access & pwrite;
  assign sel_ctl = (paddr == `ADDR_CONTROL);
  assign sel_mode = (paddr == `ADDR_HOUR_FORMAT_CONFIG);
  assign sel_time = (paddr == `ADDR_TIME_OF_DAY);
  assign sel_cal = (paddr == `ADDR_CALENDAR_DATE);
  assign sel_talm = (paddr == `ADDR_TIME_ALARM_MATCH);
  assign sel_dalm = (paddr == `ADDR_DATE_ALARM_MATCH);
  assign sel_stat = (paddr == `ADDR_EVENT_STATUS);
  assign sel_clr = (paddr == `ADDR_STATUS_CLEAR_COMMAND);
  assign sel_wp = (paddr == `ADDR_WRITE_PROTECT_CONFIG);

  assign w_hour = {2'b00, pwdata[21:16]};
  assign time_ok = bcd_in({1'b0, pwdata[6:0]}, 8'h00, 8'h59) && bcd_in({1'b0, pwdata[14:8]}, 8'h00, 8'h59) &&
    (hour_format_select ? bcd_in(w_hour, 8'h01, 8'h12) : bcd_in(w_hour, 8'h00, 8'h23));
  assign cal_ok = (pwdata[6:0] == 7'h20) && bcd_in(pwdata[15:8], 8'h00, 8'h99) &&
    bcd_in({3'b000, pwdata[20:16]}, 8'h01, 8'h12) && (pwdata[23:21] >= 3'd1) && (pwdata[23:21] <= 3'd7) &&
    bcd_in({2'b00, pwdata[29:24]}, 8'h01, 8'h31);

  // One wait state: pready rises the cycle after the access phase begins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~(sel_ctl | sel_mode | sel_time | sel_cal | sel_talm |
        sel_dalm | sel_stat | sel_clr | sel_wp);
      prdata <= 32'h0;
      if (psel & penable & ~pready & ~pwrite) begin
        unique case (1'b1)
          sel_ctl: prdata <= control;
          sel_mode: prdata <= {31'h0, hour_format_select};
          sel_time: prdata <= {9'h0, tm.meridiem, tm.hour, 1'b0, tm.minute, 1'b0, tm.second};
          sel_cal: prdata <= {2'b00, cal.date, cal.day, cal.month, cal.year, 1'b0, cal.hundred_year_value};
          sel_talm: prdata <= time_alarm;
          sel_dalm: prdata <= date_alarm;
          sel_stat: prdata <= {27'h0, status};
          sel_wp: prdata <= {31'h0, write_protect_enable};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hour_format_select <= 1'b0;
      write_protect_enable <= 1'b0;
      time_alarm <= `RESET_ALARM;
      date_alarm <= `RESET_ALARM;
      control <= 32'h0;
    end else begin
      if (wr && sel_wp)
        write_protect_enable <= pwdata[`WRITE_PROTECT_ENABLE_BIT];
      if (wr && sel_ctl)
        control <= pwdata & `CONTROL_MASK;
      if (wr && !write_protect_enable) begin
        if (sel_mode)
          hour_format_select <= pwdata[`HOUR_FORMAT_SELECT_BIT];
        if (sel_talm)
          time_alarm <= pwdata & `TIME_ALARM_MASK;
        if (sel_dalm)
          date_alarm <= pwdata & `DATE_ALARM_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Second time base and update handshake
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (tick_count == TICKS_PER_SECOND - 1);
      tick_count <= (tick_count == TICKS_PER_SECOND - 1) ? 32'h0 : tick_count + 32'h1;
    end
  end

  // Halting waits for a second boundary; the tick at that boundary does not advance the count
  logic upd_req;
  assign upd_req = control[`UPDATE_TIME_BIT] | control[`UPDATE_CAL_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
    end else begin
      unique case (state)
        ST_RUN: if (upd_req) state <= ST_HALTING;
        ST_HALTING: begin
          if (!upd_req)
            state <= ST_RUN;
          else if (tick)
            state <= ST_HALTED;
        end
        ST_HALTED: if (!upd_req) state <= ST_RUN;
        default: state <= ST_RUN;
      endcase
    end
  end

  assign advance = tick && (state != ST_HALTED) && !(state == ST_HALTING);

  // ----------------------------------------------------------------
  // Counting engine
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] s8, m8, h8, d8, mo8;
    next_tm = tm;
    next_cal = cal;
    ev_min = 1'b0;
    ev_hour = 1'b0;
    ev_noon = 1'b0;
    ev_mid = 1'b0;
    ev_week = 1'b0;
    ev_month = 1'b0;
    ev_year = 1'b0;
    s8 = {1'b0, tm.second};
    m8 = {1'b0, tm.minute};
    h8 = {2'b00, tm.hour};
    d8 = {2'b00, cal.date};
    mo8 = {3'b000, cal.month};
    if (s8 != 8'h59) begin
      next_tm.second = 7'(bcd_inc(s8));
    end else begin
      next_tm.second = 7'h0;
      ev_min = 1'b1;
      if (m8 != 8'h59) begin
        next_tm.minute = 7'(bcd_inc(m8));
      end else begin
        next_tm.minute = 7'h0;
        ev_hour = 1'b1;
        if (hour_format_select) begin
          if (h8 == 8'h11) begin
            next_tm.hour = 6'h12;
            next_tm.meridiem = ~tm.meridiem;
            ev_noon = ~tm.meridiem;
            ev_mid = tm.meridiem;
          end else if (h8 == 8'h12) begin
            next_tm.hour = 6'h01;
          end else begin
            next_tm.hour = 6'(bcd_inc(h8));
          end
        end else begin
          next_tm.meridiem = 1'b0;
          ev_mid = (h8 == 8'h23);
          ev_noon = (h8 == 8'h11);
          next_tm.hour = ev_mid ? 6'h00 : 6'(bcd_inc(h8));
        end
        if (ev_mid) begin
          // Day of week only wraps; day 1 counts as the start of a week
          ev_week = (cal.day == 3'd7);
          next_cal.day = (cal.day == 3'd7) ? 3'd1 : cal.day + 3'd1;
          if (d8 != last_date(cal.month, cal.year)) begin
            next_cal.date = 6'(bcd_inc(d8));
          end else begin
            next_cal.date = 6'h01;
            ev_month = 1'b1;
            if (mo8 != 8'h12) begin
              next_cal.month = 5'(bcd_inc(mo8));
            end else begin
              next_cal.month = 5'h01;
              ev_year = 1'b1;
              next_cal.year = (cal.year == 8'h99) ? 8'h00 : bcd_inc(cal.year);
            end
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Register words have reserved gaps the structs lack, so fields are mapped one by one
      tm <= '{meridiem: RST_TOD[22], hour: RST_TOD[21:16], minute: RST_TOD[14:8], second: RST_TOD[6:0]};
      cal <= '{date: RST_CAL[29:24], day: RST_CAL[23:21], month: RST_CAL[20:16],
        year: RST_CAL[15:8], hundred_year_value: RST_CAL[6:0]};
    end else if (wr && sel_time && state == ST_HALTED && control[`UPDATE_TIME_BIT]) begin
      if (time_ok) begin
        tm.second <= pwdata[6:0];
        tm.minute <= pwdata[14:8];
        tm.hour <= pwdata[21:16];
        tm.meridiem <= hour_format_select & pwdata[`MERIDIEM_FLAG_BIT];
      end
    end else if (wr && sel_cal && state == ST_HALTED && control[`UPDATE_CAL_BIT]) begin
      if (cal_ok)
        cal <= '{date: pwdata[29:24], day: pwdata[23:21], month: pwdata[20:16],
          year: pwdata[15:8], hundred_year_value: pwdata[6:0]};
    end else if (advance) begin
      tm <= next_tm;
      cal <= next_cal;
    end
  end

  // ----------------------------------------------------------------
  // Alarm compare and event selection
  // ----------------------------------------------------------------
  logic sec_en, min_en, hr_en, dt_en, mo_en;
  assign sec_en = time_alarm[`SECOND_MATCH_ENABLE_BIT];
  assign min_en = time_alarm[`MINUTE_MATCH_ENABLE_BIT];
  assign hr_en = time_alarm[`HOUR_MATCH_ENABLE_BIT];
  assign dt_en = date_alarm[`DATE_MATCH_ENABLE_BIT];
  assign mo_en = date_alarm[`MONTH_MATCH_ENABLE_BIT];
  assign any_en = sec_en | min_en | hr_en | dt_en | mo_en;
  // Compared one cycle after the count moves, against the settled values
  assign alarm_hit = advance_d && any_en &&
    (!sec_en || time_alarm[6:0] == tm.second) &&
    (!min_en || time_alarm[14:8] == tm.minute) &&
    (!hr_en || time_alarm[22:16] == {tm.meridiem, tm.hour}) &&
    (!dt_en || date_alarm[29:24] == cal.date) &&
    (!mo_en || date_alarm[20:16] == cal.month);

  always_comb begin
    unique case (control[`TIME_EVENT_SELECT_LSB +: 2])
      2'd0: time_ev_hit = ev_min;
      2'd1: time_ev_hit = ev_hour;
      2'd2: time_ev_hit = ev_mid;
      default: time_ev_hit = ev_noon;
    endcase
    unique case (control[`CALENDAR_EVENT_SELECT_LSB +: 2])
      2'd0: cal_ev_hit = ev_week;
      2'd1: cal_ev_hit = ev_month;
      2'd2: cal_ev_hit = ev_year;
      default: cal_ev_hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Status flags: a set in the same cycle as a clear wins
  // ----------------------------------------------------------------
  logic [4:0] clr, set;
  assign clr = (wr && sel_clr) ? pwdata[4:0] : 5'h0;
  assign set[`ST_ACK_BIT] = (state == ST_HALTING) && upd_req && tick;
  assign set[`ST_ALARM_BIT] = alarm_hit;
  assign set[`ST_SEC_BIT] = tick;
  assign set[`ST_TIME_BIT] = advance && time_ev_hit;
  assign set[`ST_CAL_BIT] = advance && cal_ev_hit;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= 5'h0;
      advance_d <= 1'b0;
    end else begin
      advance_d <= advance;
      // Acknowledge also drops once the clock runs freely again
      status <= (set | (status & ~clr)) & {4'hf, (state != ST_RUN) | set[`ST_ACK_BIT]};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wp_mode;
    wr && sel_mode && write_protect_enable |=> $stable(hour_format_select);
  endproperty
  a_wp_mode: assert property (p_wp_mode) else $error("mode written under write protection");

  property p_mode_write;
    wr && sel_mode && !write_protect_enable |=> hour_format_select == $past(pwdata[0]);
  endproperty
  a_mode_write: assert property (p_mode_write) else $error("hour format not taken");

  property p_sec_range;
    tm.second <= 7'h59 && tm.second[3:0] <= 4'h9 && tm.minute <= 7'h59 && tm.minute[3:0] <= 4'h9;
  endproperty
  a_sec_range: assert property (p_sec_range) else $error("second or minute out of range");

  property p_cal_range;
    cal.hundred_year_value == 7'h20 && cal.month >= 5'h01 && cal.month <= 5'h12 && cal.date >= 6'h01 &&
      cal.date <= 6'h31 && cal.day >= 3'd1 && cal.day <= 3'd7;
  endproperty
  a_cal_range: assert property (p_cal_range) else $error("calendar field out of range");

  property p_hour12;
    wr && sel_time && time_ok && hour_format_select && state == ST_HALTED && control[0]
      |=> tm.hour >= 6'h01 && tm.hour <= 6'h12;
  endproperty
  a_hour12: assert property (p_hour12) else $error("12-hour value out of range");

  property p_ack;
    $rose(state == ST_HALTED) |-> status[`ST_ACK_BIT];
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missing while halted");

  property p_alarm;
    alarm_hit |=> status[`ST_ALARM_BIT] [*2];
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag not raised");

  property p_sec_evt;
    tick |=> status[`ST_SEC_BIT];
  endproperty
  a_sec_evt: assert property (p_sec_evt) else $error("second event lost");

  property p_clear;
    wr && sel_clr && pwdata[1] && !alarm_hit |=> !status[`ST_ALARM_BIT];
  endproperty
  a_clear: assert property (p_clear) else $error("alarm flag not cleared");

  property p_frozen;
    state == ST_HALTED && !(wr && (sel_time || sel_cal)) |=> $stable(tm) && $stable(cal);
  endproperty
  a_frozen: assert property (p_frozen) else $error("counters moved while halted");

  property p_pready;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_pready: assert property (p_pready) else $error("APB answer timing wrong");

  c_halted: cover property (state == ST_HALTING ##[1:1000] state == ST_HALTED);
  c_alarm: cover property (alarm_hit);
  c_time_ev: cover property (set[`ST_TIME_BIT]);
  c_cal_ev: cover property (set[`ST_CAL_BIT]);

endmodule // rtc_regs

// >>> rtl/rtc_regs_consts.svh
// Register offsets, field positions, reset values and timing counts of the RTC register block
`ifndef RTC_REGS_CONSTS_SVH
`define RTC_REGS_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define ADDR_CONTROL 32'h0ffffeb0
`define ADDR_HOUR_FORMAT_CONFIG 32'h0ffffeb4
`define ADDR_TIME_OF_DAY 32'h0ffffeb8
`define ADDR_CALENDAR_DATE 32'h0ffffebc
`define ADDR_TIME_ALARM_MATCH 32'h0ffffec0
`define ADDR_DATE_ALARM_MATCH 32'h0ffffec4
`define ADDR_EVENT_STATUS 32'h0ffffec8
`define ADDR_STATUS_CLEAR_COMMAND 32'h0ffffecc
`define ADDR_WRITE_PROTECT_CONFIG 32'h0ffffee4
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define HOUR_FORMAT_SELECT_BIT 0
`define MERIDIEM_FLAG_BIT 22
`define SECOND_MATCH_ENABLE_BIT 7
`define MINUTE_MATCH_ENABLE_BIT 15
`define HOUR_MATCH_ENABLE_BIT 23
`define MONTH_MATCH_ENABLE_BIT 23
`define DATE_MATCH_ENABLE_BIT 31
`define UPDATE_TIME_BIT 0
`define UPDATE_CAL_BIT 1
`define TIME_EVENT_SELECT_LSB 8
`define CALENDAR_EVENT_SELECT_LSB 16
`define WRITE_PROTECT_ENABLE_BIT 0
`define ST_ACK_BIT 0
`define ST_ALARM_BIT 1
`define ST_SEC_BIT 2
`define ST_TIME_BIT 3
`define ST_CAL_BIT 4
// ----------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------
`define TIME_ALARM_MASK 32'h00ffffff
`define DATE_ALARM_MASK 32'hbf9f0000
`define CONTROL_MASK 32'h00030303
`define RESET_TIME_OF_DAY 32'h00000000
`define RESET_CALENDAR_DATE 32'h01210120
`define RESET_ALARM 32'h00000000
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_PS 8000
`define SECOND_PS 64'd1000000000000
`define TICKS_PER_SECOND 32'(`SECOND_PS / `CLK_PERIOD_PS)
`endif

// >>> rtl/rtc_regs_pkg.sv
// Types shared by the RTC register block
package rtc_regs_pkg;
  typedef struct packed {
    logic meridiem;
    logic [5:0] hour;
    logic [6:0] minute;
    logic [6:0] second;
  } tod_t;
  typedef struct packed {
    logic [5:0] date;
    logic [2:0] day;
    logic [4:0] month;
    logic [7:0] year;
    logic [6:0] hundred_year_value;
  } cal_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALTING = 2'b01,
    ST_HALTED = 2'b11
  } run_state_t;
endpackage

// >>> verif/rtc_regs_tb_top.sv
// Self-checking testbench for the RTC register block over APB
`timescale 1ns/1ps
`include "rtc_regs_consts.svh"

module rtc_regs_tb_top;
  import rtc_regs_pkg::*;
  // Short second keeps the midnight rollover run to a few hundred cycles
  localparam int unsigned TPS = 20;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  int errors;
  int checks_done;

  rtc_regs #(.TICKS_PER_SECOND(TPS)) i_rtc_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request stands until the rising edge that sees pready high; the answer is taken at that edge
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    chk("write error", 32'h0, {31'h0, e});
  endtask

  task automatic rd(input string what, input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(what, exp & m, r & m);
  endtask

  task automatic wait_flag(input int idx, input logic val);
    logic [31:0] r;
    logic e;
    int n = 0;
    do begin
      apb(1'b0, `ADDR_EVENT_STATUS, 32'h0, r, e);
      n++;
    end while (r[idx] !== val && n < 100);
    chk("status poll", {31'h0, val}, {31'h0, r[idx]});
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd("status", `ADDR_EVENT_STATUS, 32'h0, 32'h1f);
    rd("time", `ADDR_TIME_OF_DAY, `RESET_TIME_OF_DAY, 32'hffffffff);
    rd("calendar", `ADDR_CALENDAR_DATE, `RESET_CALENDAR_DATE, 32'hffffffff);
    rd("hour format", `ADDR_HOUR_FORMAT_CONFIG, 32'h0, 32'h1);
    rd("time alarm", `ADDR_TIME_ALARM_MATCH, `RESET_ALARM, 32'hffffffff);
    apb(1'b0, 32'h0ffffef0, 32'h0, r, e);
    chk("unmapped error", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, r);
  endtask

  task automatic t_protect();
    wr(`ADDR_WRITE_PROTECT_CONFIG, 32'h1);
    wr(`ADDR_HOUR_FORMAT_CONFIG, 32'h1);
    rd("protected mode", `ADDR_HOUR_FORMAT_CONFIG, 32'h0, 32'h1);
    wr(`ADDR_TIME_ALARM_MATCH, 32'h00000080);
    rd("protected alarm", `ADDR_TIME_ALARM_MATCH, 32'h0, 32'hffffffff);
    wr(`ADDR_WRITE_PROTECT_CONFIG, 32'h0);
    wr(`ADDR_HOUR_FORMAT_CONFIG, 32'h1);
    rd("mode", `ADDR_HOUR_FORMAT_CONFIG, 32'h1, 32'h1);
  endtask

  // Clear lands well inside one second, so no fresh tick can hide it
  task automatic t_second();
    wait_flag(`ST_SEC_BIT, 1'b1);
    wr(`ADDR_STATUS_CLEAR_COMMAND, 32'h4);
    rd("second cleared", `ADDR_EVENT_STATUS, 32'h0, 32'h4);
    wait_flag(`ST_SEC_BIT, 1'b1);
    wr(`ADDR_STATUS_CLEAR_COMMAND, 32'h0);
    rd("second kept", `ADDR_EVENT_STATUS, 32'h4, 32'h4);
  endtask

  task automatic t_update();
    wr(`ADDR_CONTROL, 32'h3);
    wait_flag(`ST_ACK_BIT, 1'b1);
    wr(`ADDR_TIME_OF_DAY, 32'h00110000);
    wr(`ADDR_TIME_OF_DAY, 32'h00106000);
    rd("bad minute", `ADDR_TIME_OF_DAY, 32'h00110000, 32'hffffffff);
    wr(`ADDR_CALENDAR_DATE, 32'h01210119);
    rd("bad century", `ADDR_CALENDAR_DATE, `RESET_CALENDAR_DATE, 32'hffffffff);
    wr(`ADDR_TIME_OF_DAY, 32'h00130000);
    rd("hour 13 in 12h", `ADDR_TIME_OF_DAY, 32'h00110000, 32'hffffffff);
    wr(`ADDR_TIME_OF_DAY, 32'h00520000);
    rd("12 pm", `ADDR_TIME_OF_DAY, 32'h00520000, 32'hffffffff);
    wr(`ADDR_HOUR_FORMAT_CONFIG, 32'h0);
    wr(`ADDR_TIME_OF_DAY, 32'h00235958);
    rd("time set", `ADDR_TIME_OF_DAY, 32'h00235958, 32'hffffffff);
    wr(`ADDR_CALENDAR_DATE, 32'h31329920);
    rd("calendar set", `ADDR_CALENDAR_DATE, 32'h31329920, 32'hffffffff);
  endtask

  // Runs through new year midnight with every alarm field armed on it
  task automatic t_alarm();
    wr(`ADDR_TIME_ALARM_MATCH, 32'h00808080);
    rd("time alarm set", `ADDR_TIME_ALARM_MATCH, 32'h00808080, 32'hffffffff);
    wr(`ADDR_DATE_ALARM_MATCH, 32'h81810000);
    rd("date alarm", `ADDR_DATE_ALARM_MATCH, 32'h81810000, 32'hffffffff);
    wr(`ADDR_STATUS_CLEAR_COMMAND, 32'h1f);
    wr(`ADDR_CONTROL, 32'h00020000);
    rd("running ack", `ADDR_EVENT_STATUS, 32'h0, 32'h3);
    wait_flag(`ST_ALARM_BIT, 1'b1);
    rd("time and year events", `ADDR_EVENT_STATUS, 32'h1a, 32'h1a);
    wr(`ADDR_CONTROL, 32'h3);
    wait_flag(`ST_ACK_BIT, 1'b1);
    rd("midnight", `ADDR_TIME_OF_DAY, 32'h0, 32'hffffffff);
    rd("new year", `ADDR_CALENDAR_DATE, 32'h01410020, 32'hffffffff);
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(8 * 40000);
    errors++;
    tally_and_finish();
  end

  initial begin
    errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_protect();
    t_second();
    t_update();
    t_alarm();
    tally_and_finish();
  end
endmodule // rtc_regs_tb_top
